// ==== adcsi_flag_cell.sv ====
// Sticky flag with set-over-clear priority
`timescale 1ns/100ps
`default_nettype none

module adcsi_flag_cell (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Control
    input wire logic set_i,
    input wire logic clr_i,
    // State
    output logic flag_o
);

    // ------------------------------------------------------------
    // Flag storage
    // ------------------------------------------------------------
    // Set wins so an event in the clearing cycle is kept
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flag_o <= 1'b0;
        end else if (set_i) begin
            flag_o <= 1'b1;
        end else if (clr_i) begin
            flag_o <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ==== adcsi_host_model.sv ====
// Host processor model driving the register port
`timescale 1ns/100ps
`default_nettype none

module adcsi_host_model
    import adcsi_pkg::*;
(
    // Clock
    input wire logic mclk_i,
    // Register port
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [ADCSI_ADDR_W-1:0] reg_addr_o,
    output logic [ADCSI_DATA_W-1:0] reg_wdata_o,
    input wire logic [ADCSI_DATA_W-1:0] reg_rdata_i,
    input wire logic reg_rvalid_i
);
    initial begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 7'h00;
        reg_wdata_o = 24'h000000;
    end

    task automatic wr_reg(input logic [6:0] a, input logic [23:0] d);
        @(posedge mclk_i);
        reg_wr_o <= 1'b1;
        reg_addr_o <= a;
        reg_wdata_o <= d;
        @(posedge mclk_i);
        reg_wr_o <= 1'b0;
        // Stale data would hide a late capture
        reg_wdata_o <= ~d;
    endtask

    task automatic rd_reg(input logic [6:0] a, output logic [23:0] d, output logic v);
        @(posedge mclk_i);
        reg_rd_o <= 1'b1;
        reg_addr_o <= a;
        @(posedge mclk_i);
        reg_rd_o <= 1'b0;
        #1;
        d = reg_rdata_i;
        v = reg_rvalid_i;
    endtask

    // Two reads on consecutive edges
    task automatic rd_two(input logic [6:0] a, output logic [23:0] d0, output logic [23:0] d1);
        @(posedge mclk_i);
        reg_rd_o <= 1'b1;
        reg_addr_o <= a;
        @(posedge mclk_i);
        #1;
        d0 = reg_rdata_i;
        @(posedge mclk_i);
        reg_rd_o <= 1'b0;
        #1;
        d1 = reg_rdata_i;
    endtask
endmodule

`default_nettype wire

// ==== adcsi_monitor.sv ====
// Port checker for the status flag and interrupt block
`timescale 1ns/100ps
`default_nettype none

module adcsi_monitor
    import adcsi_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [ADCSI_ADDR_W-1:0] reg_addr_i,
    input wire logic [ADCSI_DATA_W-1:0] reg_wdata_i,
    input wire logic [ADCSI_DATA_W-1:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    // Events
    input wire logic [ADCSI_NCHAN-1:0] over_range_evt_i,
    input wire logic [ADCSI_NCHAN-1:0] under_range_evt_i,
    input wire logic gain_cal_overflow_evt_i,
    input wire logic calibration_done_evt_i,
    input wire logic wait_done_evt_i,
    input wire logic sequence_pass_evt_i,
    input wire logic conversion_done_evt_i,
    input wire logic [ADCSI_NCHAN-1:0] data_reg_wr_i,
    input wire logic [ADCSI_NCHAN-1:0] data_reg_rd_i,
    // Interrupt and enables
    input wire logic int_req_o,
    input wire logic [ADCSI_DATA_W-1:0] interrupt_source_enable_o
);
    // ------------------------------------------------------------
    // Decodes
    // ------------------------------------------------------------
    // No setting event, so a read must leave the flags clear
    wire logic quiet = ~|{over_range_evt_i, under_range_evt_i, gain_cal_overflow_evt_i,
        calibration_done_evt_i, wait_done_evt_i, sequence_pass_evt_i, conversion_done_evt_i};
    wire logic rd_flags = reg_rd_i && (reg_addr_i == ADCSI_EVENT_FLAGS_ADDR);
    wire logic wr_en = reg_wr_i && (reg_addr_i == ADCSI_SOURCE_ENABLE_ADDR);
    wire logic rd_other = reg_rd_i && !rd_flags && (reg_addr_i != ADCSI_SOURCE_ENABLE_ADDR);

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!reset_n_i);

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    AST_RVALID_LAG: assert property (##1 reg_rvalid_o == $past(reg_rd_i))
        else $error("read valid not one cycle after read");
    AST_ENABLE_WRITE: assert property (wr_en |=>
        interrupt_source_enable_o == ($past(reg_wdata_i) & ADCSI_ENABLE_WMASK))
        else $error("enable write not taken");
    AST_ENABLE_HOLD: assert property (!wr_en |=> $stable(interrupt_source_enable_o))
        else $error("enable changed without a write");
    AST_UNUSED_ZERO: assert property (interrupt_source_enable_o[6:5] == 2'h0)
        else $error("unused enable bits set");
    AST_CONV_INT: assert property (conversion_done_evt_i && interrupt_source_enable_o[0]
        && !wr_en |-> ##2 int_req_o)
        else $error("interrupt missing after conversion event");
    AST_MASKED_QUIET: assert property ((interrupt_source_enable_o == ADCSI_ZERO_WORD)
        && !wr_en |-> ##2 !int_req_o)
        else $error("interrupt while all sources masked");
    AST_READ_CLEAR: assert property (rd_flags && quiet ##1 rd_flags && quiet |=>
        (reg_rdata_o & 24'hffffef) == ADCSI_ZERO_WORD)
        else $error("flags survived a status read");
    AST_UNREAD_KEEP: assert property (|data_reg_wr_i ##1
        (rd_flags && data_reg_rd_i == ADCSI_ZERO_CHAN)[*2] |=> reg_rdata_o[ADCSI_UNREAD_BIT])
        else $error("unread indication lost");
    AST_UNMAPPED_ZERO: assert property (rd_other |=> reg_rdata_o == ADCSI_ZERO_WORD)
        else $error("unmapped read not zero");

    cover property ($rose(int_req_o));
    cover property (rd_flags ##1 rd_flags);
    cover property (wr_en);
endmodule

`default_nettype wire

// ==== adcsi_pkg.sv ====
// Constants shared by the converter status and interrupt logic
package adcsi_pkg;

    // ------------------------------------------------------------
    // Register port geometry
    // ------------------------------------------------------------
    localparam int ADCSI_ADDR_W = 7;
    localparam int ADCSI_DATA_W = 24;
    localparam int ADCSI_NCHAN = 8;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [ADCSI_ADDR_W-1:0] ADCSI_EVENT_FLAGS_ADDR = 7'h38;
    localparam logic [ADCSI_ADDR_W-1:0] ADCSI_SOURCE_ENABLE_ADDR = 7'h39;

    // ------------------------------------------------------------
    // Field positions, shared by the flag and enable registers
    // ------------------------------------------------------------
    localparam int ADCSI_OVER_LSB = 16;
    localparam int ADCSI_UNDER_LSB = 8;
    localparam int ADCSI_GAIN_BIT = 7;
    localparam int ADCSI_UNUSED_HI_BIT = 6;
    localparam int ADCSI_UNUSED_LO_BIT = 5;
    localparam int ADCSI_UNREAD_BIT = 4;
    localparam int ADCSI_WAIT_BIT = 3;
    localparam int ADCSI_CAL_BIT = 2;
    localparam int ADCSI_SEQ_BIT = 1;
    localparam int ADCSI_CONV_BIT = 0;

    // ------------------------------------------------------------
    // Reset values and masks
    // ------------------------------------------------------------
    localparam logic [ADCSI_DATA_W-1:0] ADCSI_ENABLE_RESET = 24'h000001;
    localparam logic [ADCSI_DATA_W-1:0] ADCSI_ENABLE_WMASK = 24'hffff9f;
    localparam logic [ADCSI_DATA_W-1:0] ADCSI_ZERO_WORD = 24'h000000;
    localparam logic [ADCSI_NCHAN-1:0] ADCSI_ZERO_CHAN = 8'h00;

endpackage

// ==== adcsi_status_top.sv ====
// Status flags, source enables and interrupt line of the converter
//
// Overview of operation
// - Over-range flags 23..16, cleared by status read
// - Under-range flags 15..8, cleared by status read
// - Gain-cal overflow flag bit 7, read clears
// - Wait-complete bit 3, read or wait-start clears
// - Calibration-ready bit 2, read or cal-start clears
// - Sequence-pass bit 1, read/trigger/wraparound clears
// - Conversion-ready bit 0, read/trigger/pre-result clears
// - Interrupt is OR of enabled flags
// - Each flag has enable; 1 enables
// - Enable resets to conversion-ready only
// - Unread-result enable at bit 4
// - Enable layout mirrors flags; bits 6,5 unused
// - Unread indication is OR of eight flags
// - Valid gain calibration clears overflow flag
`timescale 1ns/100ps
`default_nettype none

module adcsi_status_top
    import adcsi_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Register access port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [ADCSI_ADDR_W-1:0] reg_addr_i,
    input wire logic [ADCSI_DATA_W-1:0] reg_wdata_i,
    output logic [ADCSI_DATA_W-1:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // Trigger register writes, one-cycle pulses
    input wire logic wait_trigger_wr_i,
    input wire logic calibration_trigger_wr_i,
    input wire logic sequence_trigger_reg_wr_i,
    input wire logic conversion_trigger_reg_wr_i,
    // Threshold comparison events per channel
    input wire logic [ADCSI_NCHAN-1:0] over_range_evt_i,
    input wire logic [ADCSI_NCHAN-1:0] under_range_evt_i,
    // Calibration events
    input wire logic gain_cal_overflow_evt_i,
    input wire logic gain_cal_valid_evt_i,
    input wire logic calibration_done_evt_i,
    // Wait and sequencer events
    input wire logic wait_done_evt_i,
    input wire logic sequence_pass_evt_i,
    input wire logic last_microcode_slot_wrap_i,
    // Conversion events
    input wire logic conversion_done_evt_i,
    input wire logic conversion_pre_result_i,
    // Data register traffic, one bit per data register
    input wire logic [ADCSI_NCHAN-1:0] data_reg_wr_i,
    input wire logic [ADCSI_NCHAN-1:0] data_reg_rd_i,
    // Interrupt and enable state
    output logic int_req_o,
    output logic [ADCSI_DATA_W-1:0] interrupt_source_enable_o
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic addr_hit(
        input logic [ADCSI_ADDR_W-1:0] addr,
        input logic [ADCSI_ADDR_W-1:0] target
    );
        addr_hit = (addr == target);
    endfunction

    wire logic status_sel;
    wire logic enable_sel;
    wire logic status_rd;
    wire logic enable_wr;

    assign status_sel = addr_hit(reg_addr_i, ADCSI_EVENT_FLAGS_ADDR);
    assign enable_sel = addr_hit(reg_addr_i, ADCSI_SOURCE_ENABLE_ADDR);
    // A status read is the common clear for most flags
    assign status_rd = reg_rd_i & status_sel;
    assign enable_wr = reg_wr_i & enable_sel;

    // ------------------------------------------------------------
    // Set and clear terms of the event flags
    // ------------------------------------------------------------
    logic [ADCSI_DATA_W-1:0] interrupt_source_enable;
    wire logic [ADCSI_DATA_W-1:0] flag_set;
    wire logic [ADCSI_DATA_W-1:0] flag_clr;
    wire logic [ADCSI_DATA_W-1:0] event_flags;
    wire logic [ADCSI_NCHAN-1:0] chan_over_range_flag;
    wire logic [ADCSI_NCHAN-1:0] chan_under_range_flag;

    // Per-channel over-range, bit per channel 7..0
    assign flag_set[ADCSI_OVER_LSB +: ADCSI_NCHAN] = over_range_evt_i;
    assign flag_clr[ADCSI_OVER_LSB +: ADCSI_NCHAN] = {ADCSI_NCHAN{status_rd}};

    // Per-channel under-range, bit per channel 7..0
    assign flag_set[ADCSI_UNDER_LSB +: ADCSI_NCHAN] = under_range_evt_i;
    assign flag_clr[ADCSI_UNDER_LSB +: ADCSI_NCHAN] = {ADCSI_NCHAN{status_rd}};

    // Gain calibration overflow
    assign flag_set[ADCSI_GAIN_BIT] = gain_cal_overflow_evt_i;
    // A later calibration with a good result also clears it
    assign flag_clr[ADCSI_GAIN_BIT] = status_rd | gain_cal_valid_evt_i;

    // Unused positions and the unread position hold no sticky flag here
    assign flag_set[ADCSI_UNUSED_HI_BIT] = 1'b0;
    assign flag_clr[ADCSI_UNUSED_HI_BIT] = 1'b0;
    assign flag_set[ADCSI_UNUSED_LO_BIT] = 1'b0;
    assign flag_clr[ADCSI_UNUSED_LO_BIT] = 1'b0;
    assign flag_set[ADCSI_UNREAD_BIT] = 1'b0;
    assign flag_clr[ADCSI_UNREAD_BIT] = 1'b0;

    // Wait operation complete
    assign flag_set[ADCSI_WAIT_BIT] = wait_done_evt_i;
    assign flag_clr[ADCSI_WAIT_BIT] = status_rd | wait_trigger_wr_i;

    // New calibration results
    assign flag_set[ADCSI_CAL_BIT] = calibration_done_evt_i;
    assign flag_clr[ADCSI_CAL_BIT] = status_rd | calibration_trigger_wr_i;

    // Sequence pass; a trigger write from inside a sequence counts too
    assign flag_set[ADCSI_SEQ_BIT] = sequence_pass_evt_i;
    assign flag_clr[ADCSI_SEQ_BIT] = status_rd | sequence_trigger_reg_wr_i
                                   | last_microcode_slot_wrap_i;

    // Conversion ready; cleared ahead of each new result when free running
    assign flag_set[ADCSI_CONV_BIT] = conversion_done_evt_i;
    assign flag_clr[ADCSI_CONV_BIT] = status_rd | conversion_trigger_reg_wr_i
                                    | conversion_pre_result_i;

    // ------------------------------------------------------------
    // Event flag storage
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < ADCSI_DATA_W; gi = gi + 1) begin : g_flag
            adcsi_flag_cell u_flag (
                .mclk_i(mclk_i),
                .reset_n_i(reset_n_i),
                .set_i(flag_set[gi]),
                .clr_i(flag_clr[gi]),
                .flag_o(event_flags[gi])
            );
        end
    endgenerate

    assign chan_over_range_flag = event_flags[ADCSI_OVER_LSB +: ADCSI_NCHAN];
    assign chan_under_range_flag = event_flags[ADCSI_UNDER_LSB +: ADCSI_NCHAN];

    // ------------------------------------------------------------
    // Unread result tracking
    // ------------------------------------------------------------
    // One flag per data register; a status read leaves them alone
    wire logic [ADCSI_NCHAN-1:0] unread_flags;
    wire logic unread_result;

    generate
        for (gi = 0; gi < ADCSI_NCHAN; gi = gi + 1) begin : g_unread
            adcsi_flag_cell u_unread (
                .mclk_i(mclk_i),
                .reset_n_i(reset_n_i),
                .set_i(data_reg_wr_i[gi]),
                .clr_i(data_reg_rd_i[gi]),
                .flag_o(unread_flags[gi])
            );
        end
    endgenerate

    assign unread_result = |unread_flags;

    // ------------------------------------------------------------
    // Status view as software sees it
    // ------------------------------------------------------------
    wire logic [ADCSI_DATA_W-1:0] unread_word;
    wire logic [ADCSI_DATA_W-1:0] status_view;

    assign unread_word = {{(ADCSI_DATA_W-1){1'b0}}, unread_result} << ADCSI_UNREAD_BIT;
    assign status_view = event_flags | unread_word;

    // ------------------------------------------------------------
    // Interrupt source enable register
    // ------------------------------------------------------------
    // Unused bits 6 and 5 are masked off; every other bit is writable,
    // including under-range channel 1
    wire logic [ADCSI_DATA_W-1:0] next_interrupt_source_enable;

    assign next_interrupt_source_enable = enable_wr
        ? (reg_wdata_i & ADCSI_ENABLE_WMASK)
        : interrupt_source_enable;

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            interrupt_source_enable <= ADCSI_ENABLE_RESET;
        end else begin
            interrupt_source_enable <= next_interrupt_source_enable;
        end
    end

    assign interrupt_source_enable_o = interrupt_source_enable;

    // ------------------------------------------------------------
    // Named enable fields
    // ------------------------------------------------------------
    wire logic [ADCSI_NCHAN-1:0] over_range_enable;
    wire logic [ADCSI_NCHAN-1:0] under_range_enable;
    wire logic gain_cal_overflow_enable;
    wire logic unread_result_enable;
    wire logic wait_complete_enable;
    wire logic calibration_ready_enable;
    wire logic sequence_pass_enable;
    wire logic conversion_ready_enable;

    assign over_range_enable = interrupt_source_enable[ADCSI_OVER_LSB +: ADCSI_NCHAN];
    assign under_range_enable = interrupt_source_enable[ADCSI_UNDER_LSB +: ADCSI_NCHAN];
    assign gain_cal_overflow_enable = interrupt_source_enable[ADCSI_GAIN_BIT];
    assign unread_result_enable = interrupt_source_enable[ADCSI_UNREAD_BIT];
    assign wait_complete_enable = interrupt_source_enable[ADCSI_WAIT_BIT];
    assign calibration_ready_enable = interrupt_source_enable[ADCSI_CAL_BIT];
    assign sequence_pass_enable = interrupt_source_enable[ADCSI_SEQ_BIT];
    assign conversion_ready_enable = interrupt_source_enable[ADCSI_CONV_BIT];

    // ------------------------------------------------------------
    // Interrupt combine
    // ------------------------------------------------------------
    // Each channel enable gates its own channel flag, channel 3 included
    wire logic chan_over_pending;
    wire logic chan_under_pending;
    wire logic misc_pending;
    wire logic next_int_req;

    assign chan_over_pending = |(chan_over_range_flag & over_range_enable);
    assign chan_under_pending = |(chan_under_range_flag & under_range_enable);
    assign misc_pending = (event_flags[ADCSI_GAIN_BIT] & gain_cal_overflow_enable)
                        | (unread_result & unread_result_enable)
                        | (event_flags[ADCSI_WAIT_BIT] & wait_complete_enable)
                        | (event_flags[ADCSI_CAL_BIT] & calibration_ready_enable)
                        | (event_flags[ADCSI_SEQ_BIT] & sequence_pass_enable)
                        | (event_flags[ADCSI_CONV_BIT] & conversion_ready_enable);
    assign next_int_req = chan_over_pending | chan_under_pending | misc_pending;

    // Registered so the pin never glitches; costs one cycle of latency
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            int_req_o <= 1'b0;
        end else begin
            int_req_o <= next_int_req;
        end
    end

    // ------------------------------------------------------------
    // Read data path
    // ------------------------------------------------------------
    // The value is captured before the read clears the flags
    wire logic [ADCSI_DATA_W-1:0] next_rdata;

    assign next_rdata = !reg_rd_i ? reg_rdata_o
                      : status_sel ? status_view
                      : enable_sel ? interrupt_source_enable
                      : ADCSI_ZERO_WORD;

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reg_rdata_o <= ADCSI_ZERO_WORD;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rdata_o <= next_rdata;
            reg_rvalid_o <= reg_rd_i;
        end
    end

endmodule

`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the status flag and interrupt block
`timescale 1ns/100ps
`default_nettype none

module testbench
    import adcsi_pkg::*;
;
    logic mclk_i, reset_n_i, wr, rd, rvalid, irq;
    logic [6:0] addr;
    logic [23:0] wdata, rdata, en, d0, d1;
    logic [11:0] ev;
    logic [7:0] ovr, und, dwr, drd;
    logic [31:0] seed = 32'hc5ae;
    int bad_count, check_count;
    int pos[5] = '{0, 1, 2, 3, 7};
    int clr[2][5] = '{'{6, 7, 8, 9, 5}, '{11, 10, 8, 9, 5}};

    adcsi_status_top DUT (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .wait_trigger_wr_i(ev[9]), .calibration_trigger_wr_i(ev[8]),
        .sequence_trigger_reg_wr_i(ev[7]), .conversion_trigger_reg_wr_i(ev[6]),
        .over_range_evt_i(ovr), .under_range_evt_i(und), .gain_cal_overflow_evt_i(ev[4]),
        .gain_cal_valid_evt_i(ev[5]), .calibration_done_evt_i(ev[2]),
        .wait_done_evt_i(ev[3]), .sequence_pass_evt_i(ev[1]),
        .last_microcode_slot_wrap_i(ev[10]), .conversion_done_evt_i(ev[0]),
        .conversion_pre_result_i(ev[11]), .data_reg_wr_i(dwr), .data_reg_rd_i(drd),
        .int_req_o(irq), .interrupt_source_enable_o(en));
    adcsi_host_model host (.mclk_i(mclk_i), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
        .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic logic [23:0] bitv(input int p);
        return 24'h000001 << p;
    endfunction

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [6:0] a, input logic [23:0] e);
        logic [23:0] d;
        logic v;
        host.rd_reg(a, d, v);
        chk({23'h000000, v}, 24'h000001);
        chk(d, e);
    endtask
    task automatic fire(input logic [11:0] e, input logic [7:0] o, u, w, r);
        @(posedge mclk_i);
        {ev, ovr, und, dwr, drd} <= {e, o, u, w, r};
        @(posedge mclk_i);
        {ev, ovr, und, dwr, drd} <= 44'h00000000000;
    endtask
    task automatic irq_is(input logic e);
        @(posedge mclk_i);
        #1;
        chk({23'h000000, irq}, {23'h000000, e});
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end
    initial begin
        #200000;
        bad_count++;
        $display("[ERR] %0t watchdog expired", $time);
        end_sim;
    end

    initial begin
        {ev, ovr, und, dwr, drd} = 44'h00000000000;
        reset_n_i = 1'b0;
        repeat (2) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        rdc(ADCSI_SOURCE_ENABLE_ADDR, 24'h000001);
        rdc(ADCSI_EVENT_FLAGS_ADDR, 24'h000000);
        for (int k = 0; k < 4; k++) begin
            seed = xs(seed);
            host.wr_reg(ADCSI_SOURCE_ENABLE_ADDR, seed[23:0]);
            rdc(ADCSI_SOURCE_ENABLE_ADDR, seed[23:0] & 24'hffff9f);
            chk(en, seed[23:0] & 24'hffff9f);
        end
        host.wr_reg(ADCSI_EVENT_FLAGS_ADDR, 24'hffffff);
        rdc(ADCSI_EVENT_FLAGS_ADDR, 24'h000000);
        rdc(7'h10, 24'h000000);
        host.wr_reg(ADCSI_SOURCE_ENABLE_ADDR, 24'h000000);
        $display("test registers done");
        for (int i = 0; i < 5; i++) begin
            fire(12'h001 << i, 8'h00, 8'h00, 8'h00, 8'h00);
            host.rd_two(ADCSI_EVENT_FLAGS_ADDR, d0, d1);
            chk(d0, bitv(pos[i]));
            chk(d1, 24'h000000);
            for (int j = 0; j < 2; j++) begin
                fire(12'h001 << i, 8'h00, 8'h00, 8'h00, 8'h00);
                fire(12'h001 << clr[j][i], 8'h00, 8'h00, 8'h00, 8'h00);
                rdc(ADCSI_EVENT_FLAGS_ADDR, 24'h000000);
            end
        end
        for (int k = 0; k < 4; k++) begin
            seed = xs(seed);
            fire(12'h000, seed[7:0], seed[15:8], 8'h00, 8'h00);
            rdc(ADCSI_EVENT_FLAGS_ADDR, {seed[7:0], seed[15:8], 8'h00});
            rdc(ADCSI_EVENT_FLAGS_ADDR, 24'h000000);
        end
        fork
            rdc(ADCSI_EVENT_FLAGS_ADDR, 24'h000000);
            fire(12'h001, 8'h00, 8'h00, 8'h00, 8'h00);
        join
        rdc(ADCSI_EVENT_FLAGS_ADDR, 24'h000001);
        $display("test flags done");
        for (int i = 0; i < 5; i++) begin
            host.wr_reg(ADCSI_SOURCE_ENABLE_ADDR, bitv(pos[i]));
            fire(12'h001 << i, 8'h00, 8'h00, 8'h00, 8'h00);
            irq_is(1'b1);
            host.wr_reg(ADCSI_SOURCE_ENABLE_ADDR, 24'h000000);
            irq_is(1'b0);
            rdc(ADCSI_EVENT_FLAGS_ADDR, bitv(pos[i]));
        end
        host.wr_reg(ADCSI_SOURCE_ENABLE_ADDR, 24'h080000);
        fire(12'h000, 8'h08, 8'h00, 8'h00, 8'h00);
        irq_is(1'b1);
        host.wr_reg(ADCSI_SOURCE_ENABLE_ADDR, 24'h010000);
        irq_is(1'b0);
        rdc(ADCSI_EVENT_FLAGS_ADDR, 24'h080000);
        host.wr_reg(ADCSI_SOURCE_ENABLE_ADDR, bitv(ADCSI_UNREAD_BIT));
        fork
            fire(12'h000, 8'h00, 8'h00, 8'h21, 8'h00);
            begin
                @(posedge mclk_i);
                host.rd_two(ADCSI_EVENT_FLAGS_ADDR, d0, d1);
            end
        join
        chk(d0, bitv(ADCSI_UNREAD_BIT));
        chk(d1, bitv(ADCSI_UNREAD_BIT));
        irq_is(1'b1);
        fire(12'h000, 8'h00, 8'h00, 8'h00, 8'h01);
        rdc(ADCSI_EVENT_FLAGS_ADDR, bitv(ADCSI_UNREAD_BIT));
        fire(12'h000, 8'h00, 8'h00, 8'h00, 8'h20);
        rdc(ADCSI_EVENT_FLAGS_ADDR, 24'h000000);
        irq_is(1'b0);
        $display("test interrupts done");
        end_sim;
    end
endmodule

bind adcsi_status_top adcsi_monitor mon (.*);

`default_nettype wire
